// ===== dv/rcri_core_model.sv
// Core-side model: a program counter that follows load pulses, offers
// the next address, and takes the vector one instruction after a wake.
// Assumes the initialiser's core-side ports on the same clock.
`timescale 1ns/1ps
module rcri_core_model
  import rcri_pkg::*;
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst_b,
  // From the initialiser
  input  wire logic [PC_W-1:0] pcValue,
  input  wire logic            pcLoad,
  input  wire logic            vectorReq,
  // To the initialiser and the bench
  output logic      [PC_W-1:0] pcNext,
  output logic                 vectorAck,
  output logic      [PC_W-1:0] corePc
);
  ////////////////////////////////////////////////////////////////////////
  logic step_q;

  // Sleeping core does not advance, so next address is held
  assign pcNext = corePc + 13'h0001;

  // Load wins; a vector request first runs one instruction, then jumps
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      corePc    <= 13'h0000;
      vectorAck <= 1'b0;
      step_q    <= 1'b0;
    end else begin
      vectorAck <= 1'b0;
      if (pcLoad) begin
        corePc <= pcValue;
      end else if (step_q) begin
        corePc    <= PC_INT_VEC;
        vectorAck <= 1'b1;
        step_q    <= 1'b0;
      end else if (vectorReq && !vectorAck) begin
        corePc <= pcNext;
        step_q <= 1'b1;
      end
    end
  end
endmodule // rcri_core_model

// ===== dv/tb_top.sv
// Self-checking bench: APB register calls and cause events in sequence.
// Assumes the initialiser faces the core model; enable dropped once.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin \
  n_errors++; $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module tb_top
  import rcri_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////
  logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1;
  logic powerOnReq = 1'b0, brownoutReq = 1'b0, extResetPin_b = 1'b1;
  logic watchdogTimeout = 1'b0, intWake = 1'b0, sleeping = 1'b0;
  logic globalIntEnable = 1'b0, vectorAck, pcLoad, vectorReq, regInit;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq;
  logic [PC_W-1:0]   pcNext, pcValue, corePc;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [DATA_W-1:0] pwdata = 32'h0000_0000, prdata;
  logic [7:0]        coreStatus;
  logic [1:0]        powerCause;
  rcri_prof_e        lastProfile;
  int                n_errors = 0, n_compared = 0;

  // 50 MHz core clock
  always #10 clk = ~clk;

  rcri_init DUT (.clk(clk), .rst_b(rst_b), .ce(ce),
    .powerOnReq(powerOnReq), .brownoutReq(brownoutReq),
    .extResetPin_b(extResetPin_b), .watchdogTimeout(watchdogTimeout),
    .intWake(intWake), .sleeping(sleeping),
    .globalIntEnable(globalIntEnable), .pcNext(pcNext),
    .vectorAck(vectorAck), .pcValue(pcValue), .pcLoad(pcLoad),
    .coreStatus(coreStatus), .powerCause(powerCause),
    .vectorReq(vectorReq), .regInit(regInit), .lastProfile(lastProfile),
    .irq(irq), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  rcri_core_model CORE (.clk(clk), .rst_b(rst_b), .pcValue(pcValue),
    .pcLoad(pcLoad), .vectorReq(vectorReq), .pcNext(pcNext),
    .vectorAck(vectorAck), .corePc(corePc));

  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run, reached from the sequence and from timeouts
  task automatic final_report();
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [ADDR_W-1:0] ad(input logic [IDX_W-1:0] idx);
    return {idx, 2'b00};
  endfunction

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d,
                     output logic [DATA_W-1:0] rd, output logic er);
    int i;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      final_report();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next call never reassigns psel in this step
    @(posedge clk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [DATA_W-1:0] rd;
    logic              er;
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] ex,
                     input logic exErr);
    logic [DATA_W-1:0] rd;
    logic              er;
    apb(1'b0, a, 32'h0000_0000, rd, er);
    `CHK("prdata", ex, rd)
    `CHK("pslverr", exErr, er)
  endtask

  // Waits for the load pulse, then checks the profile outputs
  task automatic ev(input rcri_prof_e p, input logic [PC_W-1:0] pc,
                    input logic ri, input logic [7:0] st,
                    input logic [7:0] sm, input logic [1:0] pw,
                    input logic [1:0] pm);
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (pcLoad === 1'b1) break;
    end
    if (i == 40) begin
      n_errors++;
      final_report();
    end
    `CHK("lastProfile", p, lastProfile)
    `CHK("pcValue", pc, pcValue)
    `CHK("regInit", ri, regInit)
    `CHK("coreStatus", st, coreStatus & sm)
    `CHK("powerCause", pw, powerCause & pm)
  endtask

  // One-cycle core-clock pulse on a watchdog or wake input
  task automatic pulse(input logic wdt);
    if (wdt) watchdogTimeout <= 1'b1;
    else intWake <= 1'b1;
    @(posedge clk);
    watchdogTimeout <= 1'b0;
    intWake         <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin : seq
    int i, seen;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdc(ad(IDX_STAT), 32'h18, 1'b0);
    rdc(ad(IDX_PWR), 32'h0, 1'b0);
    rdc(12'h3FC, 32'h0, 1'b1);
    wr(ad(IDX_PWR), 32'h3);
    wr(ad(IDX_IRQM), 32'h7F);
    wr(ad(IDX_STAT), 32'hE7);
    rdc(ad(IDX_STAT), 32'hFF, 1'b0);
    pulse(1'b1);
    ev(PRF_WDTRST, 13'h0, 1'b1, 8'h0F, 8'hFF, 2'h3, 2'h3);
    `CHK("irq", 1'b1, irq)
    rdc(ad(IDX_IRQS), 32'h10, 1'b0);
    rdc(ad(IDX_IRQS), 32'h0, 1'b0);
    `CHK("irq", 1'b0, irq)
    wr(ad(IDX_IRQM), 32'h0);
    wr(ad(IDX_STAT), 32'hE7);
    extResetPin_b <= 1'b0;
    ev(PRF_PRUN, 13'h0, 1'b1, 8'h0F, 8'hFF, 2'h3, 2'h3);
    extResetPin_b <= 1'b1;
    `CHK("irq", 1'b0, irq)
    wr(ad(IDX_IRQM), 32'h4);
    `CHK("irq", 1'b1, irq)
    rdc(ad(IDX_IRQS), 32'h4, 1'b0);
    `CHK("irq", 1'b0, irq)
    wr(ad(IDX_STAT), 32'hE7);
    sleeping <= 1'b1;
    repeat (8) @(posedge clk);
    extResetPin_b <= 1'b0;
    ev(PRF_PSLEEP, 13'h0, 1'b1, 8'h17, 8'hFF, 2'h3, 2'h3);
    extResetPin_b <= 1'b1;
    wr(ad(IDX_PCL), 32'h5A);
    pulse(1'b1);
    ev(PRF_WDTWK, 13'h05B, 1'b0, 8'h07, 8'hFF, 2'h3, 2'h3);
    for (i = 0; i < 2; i++) begin
      wr(ad(IDX_STAT), 32'hE7);
      globalIntEnable <= i[0];
      pulse(1'b0);
      ev(PRF_INTWK, 13'h05C + i[12:0], 1'b0, 8'hF7, 8'hFF, 2'h3,
         2'h3);
      `CHK("vectorReq", i[0], vectorReq)
    end
    for (i = 0; i < 20 && vectorReq === 1'b1; i++) @(posedge clk);
    `CHK("vectorReq", 1'b0, vectorReq)
    `CHK("corePc", 13'h0004, corePc)
    sleeping <= 1'b0;
    @(posedge clk);
    seen = 0;
    pulse(1'b0);
    repeat (10) begin
      @(posedge clk);
      if (pcLoad !== 1'b0) seen++;
    end
    `CHK("ignoredWake", 0, seen)
    brownoutReq <= 1'b1;
    ev(PRF_BOR, 13'h0, 1'b1, 8'h1F, 8'hFF, 2'h2, 2'h3);
    // Enable low: watchdog pulse must not act, read answer must stall
    ce <= 1'b0;
    pulse(1'b1);
    fork
      rdc(ad(IDX_CAUSE), 32'h2, 1'b0);
      begin
        repeat (3) @(posedge clk);
        ce <= 1'b1;
      end
    join
    brownoutReq <= 1'b0;
    wr(ad(IDX_PWR), 32'h3);
    powerOnReq    <= 1'b1;
    extResetPin_b <= 1'b0;
    ev(PRF_POR, 13'h0, 1'b1, 8'h18, 8'hF8, 2'h0, 2'h2);
    powerOnReq    <= 1'b0;
    extResetPin_b <= 1'b1;
    repeat (10) @(posedge clk);
    final_report();
  end
endmodule // tb_top

// ===== src/rcri_init.sv
// Reset condition initialiser: picks one initialisation profile per
// reset or wake event, sets program counter, status and cause bits.
// Assumes core-clock logic for watchdog, sleep and interrupt inputs and
// asynchronous levels for power-on, brown-out and the reset pin.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module rcri_init
  import rcri_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              ce,
  // Asynchronous cause levels
  input  wire logic              powerOnReq,
  input  wire logic              brownoutReq,
  input  wire logic              extResetPin_b,
  // Core-clock causes
  input  wire logic              watchdogTimeout,
  input  wire logic              intWake,
  input  wire logic              sleeping,
  input  wire logic              globalIntEnable,
  input  wire logic [PC_W-1:0]   pcNext,
  input  wire logic              vectorAck,
  // Core side
  output logic      [PC_W-1:0]   pcValue,
  output logic                   pcLoad,
  output logic      [7:0]        coreStatus,
  output logic      [1:0]        powerCause,
  output logic                   vectorReq,
  output logic                   regInit,
  output rcri_prof_e             lastProfile,
  output logic                   irq,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic addrIs(logic [ADDR_W-1:0] a,
                                  logic [IDX_W-1:0] idx);
    addrIs = (a == {idx, 2'b00});
  endfunction

  // Priority: power-on beats all, then brown-out, pin, watchdog, wake
  function automatic rcri_prof_e classify(logic por, logic bor,
                                          logic pin, logic slp,
                                          logic wdt, logic iwk);
    if (por) begin
      classify = PRF_POR;
    end else if (bor) begin
      classify = PRF_BOR;
    end else if (pin) begin
      classify = slp ? PRF_PSLEEP : PRF_PRUN;
    end else if (wdt) begin
      classify = slp ? PRF_WDTWK : PRF_WDTRST;
    end else if (iwk && slp) begin
      classify = PRF_INTWK;
    end else begin
      classify = PRF_NONE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Synchronised cause levels: {pin, brown-out, power-on}
  logic [2:0] lvlSync;
  logic [2:0] lvlRise;

  rcri_sync #(
    .W       (3)
  ) u_sync (
    .clk     (clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .asyncIn ({~extResetPin_b, brownoutReq, powerOnReq}),
    .syncOut (lvlSync)
  );

  rcri_state_s cur_q;
  rcri_state_s nxt_d;
  rcri_prof_e  prof;
  logic        setup;
  logic        access;
  logic        mapped;
  logic [NPROF-1:0] evtBits;

  // Edges of the level causes; pulses come straight from core logic
  assign lvlRise = lvlSync & ~cur_q.lvlPrev;
  assign prof    = classify(lvlRise[0], lvlRise[1], lvlRise[2], sleeping,
                            watchdogTimeout, intWake);
  // Setup missed while enable was low is taken in the access phase
  assign setup   = psel && (!penable || !cur_q.armed);
  assign access  = psel && penable && ce && cur_q.armed;
  assign mapped  = addrIs(paddr, IDX_PCL) || addrIs(paddr, IDX_STAT) ||
                   addrIs(paddr, IDX_PWR) || addrIs(paddr, IDX_IRQS) ||
                   addrIs(paddr, IDX_IRQM) || addrIs(paddr, IDX_CAUSE);

  // One status bit per profile, bit n-1 for profile code n
  always_comb begin
    evtBits = '0;
    if (prof != PRF_NONE) begin
      evtBits[3'(prof - 3'd1)] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    nxt_d         = cur_q;
    nxt_d.lvlPrev = lvlSync;
    nxt_d.pcLoad  = 1'b0;
    nxt_d.regInit = 1'b0;
    // Profile application
    case (prof)
      PRF_POR: begin
        nxt_d.pc           = PC_RESET;
        nxt_d.status[7:3]  = ST_HI_POR;
        nxt_d.pwr[PWR_POR] = 1'b0;
        nxt_d.vecReq       = 1'b0;
        nxt_d.regInit      = 1'b1;
      end
      PRF_BOR: begin
        nxt_d.pc           = PC_RESET;
        nxt_d.status[7:3]  = ST_HI_POR;
        nxt_d.pwr[PWR_BOR] = 1'b0;
        nxt_d.vecReq       = 1'b0;
        nxt_d.regInit      = 1'b1;
      end
      PRF_PRUN: begin
        nxt_d.pc          = PC_RESET;
        nxt_d.status[7:5] = ST_HI_PRUN;
        nxt_d.vecReq      = 1'b0;
        nxt_d.regInit     = 1'b1;
      end
      PRF_PSLEEP: begin
        nxt_d.pc          = PC_RESET;
        nxt_d.status[7:4] = ST_HI_PSLEEP;
        nxt_d.status[ST_PD] = 1'b0;
        nxt_d.vecReq      = 1'b0;
        nxt_d.regInit     = 1'b1;
      end
      PRF_WDTRST: begin
        nxt_d.pc          = PC_RESET;
        nxt_d.status[7:4] = ST_HI_WDT;
        nxt_d.vecReq      = 1'b0;
        nxt_d.regInit     = 1'b1;
      end
      PRF_WDTWK: begin
        nxt_d.pc            = pcNext;
        nxt_d.status[ST_TO] = 1'b0;
        nxt_d.status[ST_PD] = 1'b0;
      end
      PRF_INTWK: begin
        nxt_d.pc            = pcNext;
        nxt_d.status[ST_TO] = 1'b1;
        nxt_d.status[ST_PD] = 1'b0;
        nxt_d.vecReq        = globalIntEnable;
      end
      default: begin
        if (vectorAck) begin
          nxt_d.vecReq = 1'b0;
        end
      end
    endcase
    if (prof != PRF_NONE) begin
      nxt_d.pcLoad   = 1'b1;
      nxt_d.lastProf = prof;
    end
    // APB setup: capture read data and error for a flopped answer
    nxt_d.rdClr = '0;
    if (setup) begin
      nxt_d.armed  = 1'b1;
      nxt_d.perr   = !mapped;
      nxt_d.prdata = '0;
      if (addrIs(paddr, IDX_PCL)) begin
        nxt_d.prdata[7:0] = cur_q.pc[7:0];
      end
      if (addrIs(paddr, IDX_STAT)) begin
        nxt_d.prdata[7:0] = cur_q.status;
      end
      if (addrIs(paddr, IDX_PWR)) begin
        nxt_d.prdata[1:0] = cur_q.pwr;
      end
      if (addrIs(paddr, IDX_IRQS)) begin
        nxt_d.prdata[NPROF-1:0] = cur_q.irqStat;
        nxt_d.rdClr = pwrite ? '0 : cur_q.irqStat;
      end
      if (addrIs(paddr, IDX_IRQM)) begin
        nxt_d.prdata[NPROF-1:0] = cur_q.irqMask;
      end
      if (addrIs(paddr, IDX_CAUSE)) begin
        nxt_d.prdata[2:0] = cur_q.lastProf;
      end
    end else if (access) begin
      nxt_d.armed = 1'b0;
      nxt_d.rdClr = cur_q.rdClr;
    end
    // APB write at the access edge; a cause event this cycle wins, except over the interrupt mask write
    if (access && pwrite && prof == PRF_NONE) begin
      if (addrIs(paddr, IDX_PCL)) begin
        nxt_d.pc[7:0] = pwdata[7:0];
        nxt_d.pcLoad  = 1'b1;
      end
      if (addrIs(paddr, IDX_STAT)) begin
        // Timeout and power-down flags stay hardware-owned
        nxt_d.status[7:5] = pwdata[7:5];
        nxt_d.status[2:0] = pwdata[2:0];
      end
      if (addrIs(paddr, IDX_PWR)) begin
        nxt_d.pwr = pwdata[1:0];
      end
    end
    if (access && pwrite && addrIs(paddr, IDX_IRQM)) begin
      nxt_d.irqMask = pwdata[NPROF-1:0];
    end
    // Read-to-clear of captured bits; a new event still sets
    nxt_d.irqStat = cur_q.irqStat;
    if (access && !pwrite) begin
      nxt_d.irqStat = cur_q.irqStat & ~cur_q.rdClr;
    end
    nxt_d.irqStat = nxt_d.irqStat | evtBits;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; enable low freezes everything
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_q          <= '0;
      cur_q.pc       <= PC_RESET;
      cur_q.status   <= STAT_RESET;
      cur_q.pwr      <= PWR_RESET;
      cur_q.irqMask  <= IRQM_RESET;
      cur_q.lastProf <= PRF_NONE;
    end else if (ce) begin
      cur_q <= nxt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign pcValue     = cur_q.pc;
  assign pcLoad      = cur_q.pcLoad;
  assign coreStatus  = cur_q.status;
  assign powerCause  = cur_q.pwr;
  assign vectorReq   = cur_q.vecReq;
  assign regInit     = cur_q.regInit;
  assign lastProfile = cur_q.lastProf;
  assign irq         = |(cur_q.irqStat & cur_q.irqMask);
  assign prdata      = cur_q.prdata;
  // Answer one cycle after setup; stalls while enable is low
  assign pready      = psel && penable && ce && cur_q.armed;
  assign pslverr     = pready && cur_q.perr;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic evtCe;
  assign evtCe = ce && (prof != PRF_NONE);

  a_por_init: assert property (
    ce && prof == PRF_POR |=> pcValue == PC_RESET &&
      coreStatus[7:3] == ST_HI_POR && !powerCause[PWR_POR] && regInit)
    else $error("power-on profile not applied");

  a_prun_init: assert property (
    ce && prof == PRF_PRUN |=> pcValue == PC_RESET &&
      coreStatus[7:5] == 3'h0 &&
      coreStatus[4:0] == $past(coreStatus[4:0]) &&
      powerCause == $past(powerCause))
    else $error("pin reset while running wrong");

  a_psleep_init: assert property (
    ce && prof == PRF_PSLEEP |=> pcValue == PC_RESET &&
      coreStatus[7:3] == 5'h02 &&
      coreStatus[2:0] == $past(coreStatus[2:0]))
    else $error("pin reset in sleep wrong");

  a_wdt_reset: assert property (
    ce && prof == PRF_WDTRST |=> pcValue == PC_RESET &&
      coreStatus[7:4] == 4'h0 &&
      coreStatus[3:0] == $past(coreStatus[3:0]) &&
      powerCause == $past(powerCause))
    else $error("watchdog reset wrong");

  a_bor_cause: assert property (
    ce && prof == PRF_BOR |=> !powerCause[PWR_BOR] &&
      powerCause[PWR_POR] == $past(powerCause[PWR_POR]) &&
      coreStatus[7:3] == ST_HI_POR && pcValue == PC_RESET)
    else $error("brown-out profile wrong");

  a_int_wake: assert property (
    ce && prof == PRF_INTWK |=> pcValue == $past(pcNext) &&
      coreStatus[ST_TO] && !coreStatus[ST_PD] &&
      coreStatus[7:5] == $past(coreStatus[7:5]))
    else $error("interrupt wake wrong");

  a_wdt_wake: assert property (
    ce && prof == PRF_WDTWK |=> pcValue == $past(pcNext) &&
      coreStatus[4:3] == 2'b00 &&
      coreStatus[2:0] == $past(coreStatus[2:0]))
    else $error("watchdog wake wrong");

  a_vector_req: assert property (
    ce && prof == PRF_INTWK && globalIntEnable
      |=> vectorReq ##1 (vectorReq || $past(vectorAck)))
    else $error("vector request not raised");

  a_wake_keep: assert property (
    evtCe && (prof == PRF_INTWK || prof == PRF_WDTWK)
      |=> !regInit && powerCause == $past(powerCause))
    else $error("wake-up disturbed registers");

  a_por_wins: assert property (
    ce && lvlRise[0] |-> prof == PRF_POR)
    else $error("power-on did not take priority");

  a_unimpl_zero: assert property (
    pready && !pslverr && addrIs(paddr, IDX_PWR) |-> prdata[31:2] == '0)
    else $error("unimplemented bits not zero");

  a_one_event: assert property (
    evtCe |-> $onehot0(evtBits) ##1
      (pcLoad && lastProfile == $past(prof)))
    else $error("profile selection not unique");

endmodule // rcri_init

// ===== src/rcri_pkg.sv
// Constants, types and state layout of the reset condition initialiser.
// Assumes one core clock; every module but the synchroniser imports the whole package.
package rcri_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int PC_W    = 13;
  localparam int ADDR_W  = 12;
  localparam int DATA_W  = 32;
  localparam int IDX_W   = 10;
  localparam int NPROF   = 7;

  ////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PCL   = 10'h002;
  localparam logic [IDX_W-1:0] IDX_STAT  = 10'h003;
  localparam logic [IDX_W-1:0] IDX_PWR   = 10'h08E;
  localparam logic [IDX_W-1:0] IDX_IRQS  = 10'h040;
  localparam logic [IDX_W-1:0] IDX_IRQM  = 10'h041;
  localparam logic [IDX_W-1:0] IDX_CAUSE = 10'h042;

  ////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int ST_TO    = 4;
  localparam int ST_PD    = 3;
  localparam int PWR_BOR  = 0;
  localparam int PWR_POR  = 1;

  ////////////////////////////////////////////////////////////////////////
  // Reset and initialisation values
  localparam logic [PC_W-1:0] PC_RESET     = 13'h0000;
  localparam logic [PC_W-1:0] PC_INT_VEC   = 13'h0004;
  localparam logic [7:0]      STAT_RESET   = 8'h18;
  localparam logic [1:0]      PWR_RESET    = 2'h0;
  localparam logic [4:0]      ST_HI_POR    = 5'h03;
  localparam logic [3:0]      ST_HI_PSLEEP = 4'h1;
  localparam logic [3:0]      ST_HI_WDT    = 4'h0;
  localparam logic [2:0]      ST_HI_PRUN   = 3'h0;
  localparam logic [NPROF-1:0] IRQM_RESET  = 7'h00;

  ////////////////////////////////////////////////////////////////////////
  // Initialisation profiles; each but PRF_NONE sets one interrupt status bit
  typedef enum logic [2:0] {
    PRF_NONE   = 3'b000,
    PRF_POR    = 3'b001,
    PRF_BOR    = 3'b010,
    PRF_PRUN   = 3'b011,
    PRF_PSLEEP = 3'b100,
    PRF_WDTRST = 3'b101,
    PRF_WDTWK  = 3'b110,
    PRF_INTWK  = 3'b111
  } rcri_prof_e;

  // Complete state of the main module
  typedef struct packed {
    logic [PC_W-1:0]   pc;
    logic [7:0]        status;
    logic [1:0]        pwr;
    logic [NPROF-1:0]  irqStat;
    logic [NPROF-1:0]  irqMask;
    rcri_prof_e        lastProf;
    logic              vecReq;
    logic              pcLoad;
    logic              regInit;
    logic [2:0]        lvlPrev;
    logic [DATA_W-1:0] prdata;
    logic              perr;
    logic              armed;
    logic [NPROF-1:0]  rdClr;
  } rcri_state_s;

endpackage

// ===== src/rcri_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous inputs; output changes when stages two and three
// agree, so a single-cycle glitch past stage one is never seen.
`timescale 1ns/1ps
module rcri_sync #(
  parameter int W = 3
) (
  // Clock, reset, enable
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] stage1_q;
  logic [W-1:0] stage2_q;
  logic [W-1:0] stage3_q;

  ////////////////////////////////////////////////////////////////////////
  // Stage one feeds only stage two
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1_q <= '0;
      stage2_q <= '0;
      stage3_q <= '0;
      syncOut  <= '0;
    end else if (ce) begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      for (int i = 0; i < W; i++) begin
        if (stage2_q[i] == stage3_q[i]) begin
          syncOut[i] <= stage3_q[i];
        end
      end
    end
  end

endmodule // rcri_sync
